/* logic/rcd_pkg.sv */
// Constants, command codes and register map of the remote command decoder
//------------------------------------------------------------------------
// Notes on behaviour
// - Start-falling command selects falling start edge
// - Stop commands pick rising or falling stop edge
// - Stop falling: only falling stop closes window
// - Qualifier high: accept clocks only when high
// - Qualifier low: accept clocks only when low
// - Probe off: ignore switch, clear four functions
// - Probe on: enable switch, clear, arm trigger
// - Triggered send: next signature after trigger
// - Unstable send: next signature flagged unstable
// - Current logic send: probe tip sampled now
// - Triggered logic send: tip held at trigger
// - Four digit load commands, one per digit
// - Compatibility commands keep their older meanings
// - Start-rising command selects rising start edge
// - Recall stays off until enabled again
//------------------------------------------------------------------------
package rcd_pkg;
	// Register offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_SETTINGS = 8'h04;
	localparam logic [7:0] OFF_RESP = 8'h08;
	localparam logic [7:0] OFF_DIGITS = 8'h0c;
	localparam logic [7:0] OFF_INT_STATUS = 8'h10;
	localparam logic [7:0] OFF_INT_MASK = 8'h14;
	// Command word layout
	localparam int CMD_C2_LSB = 0;
	localparam int CMD_C1_LSB = 8;
	localparam int CMD_C0_LSB = 16;
	localparam int CMD_ARG_LSB = 24;
	// Characters
	localparam logic [7:0] CH_NUL = 8'h00;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_2 = 8'h32;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_D = 8'h44;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_I = 8'h49;
	localparam logic [7:0] CH_L = 8'h4c;
	localparam logic [7:0] CH_P = 8'h50;
	localparam logic [7:0] CH_Q = 8'h51;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_U = 8'h55;
	// Function setting bits
	localparam int FN_RECALL = 0;
	localparam int FN_QUALIFIER_INPUT = 4;
	localparam int FN_W = 5;
	localparam logic [FN_W-1:0] FN_PROBE_CLR = 5'h0f;
	localparam logic [FN_W-1:0] FN_RST = 5'h00;
	localparam logic [FN_W-1:0] FN_PRESET_QUALIFIER_INPUT = 5'h10;
	// Receive-polarities argument bits, one means rising
	localparam int RP_CLK_BIT = 0;
	localparam int RP_START_BIT = 1;
	localparam int RP_STOP_BIT = 2;
	// Settings readback layout
	localparam int SET_CLK_FALL = 5;
	localparam int SET_START_FALL = 6;
	localparam int SET_STOP_FALL = 7;
	localparam int SET_QUALIFIER_INPUT_LOW = 8;
	localparam int SET_PROBE_EN = 9;
	localparam int SET_ERROR = 10;
	// Response layout, interrupts, probe tip
	localparam int RESP_KIND_LSB = 28;
	localparam int INT_RESP = 0;
	localparam int INT_ERR = 1;
	localparam int INT_TRIG = 2;
	localparam int INT_W = 3;
	localparam int TIP_W = 2;
	localparam int NUM_DIGITS = 4;
	localparam logic PROBE_EN_RST = 1'b1;

	typedef enum logic [4:0] {
		op_none = 5'h00, start_rise_cmd = 5'h01, start_fall_cmd = 5'h02,
		stop_rise_cmd = 5'h03, stop_fall_cmd = 5'h04, qualifier_high_cmd = 5'h05,
		qualifier_low_cmd = 5'h06, clk_rise_cmd = 5'h07, clk_fall_cmd = 5'h08,
		probe_switch_off_cmd = 5'h09, probe_switch_on_cmd = 5'h0a,
		send_triggered_signature_cmd = 5'h0b, send_unstable_signature_cmd = 5'h0c,
		send_current_logic_cmd = 5'h0d, send_triggered_logic_cmd = 5'h0e,
		send_error_cmd = 5'h0f, send_pol_cmd = 5'h10, send_id_cmd = 5'h11,
		send_trig_bit_cmd = 5'h12, load_pol_cmd = 5'h13, load_digit_cmd = 5'h14,
		preset_norm_cmd = 5'h15, preset_qualifier_input_cmd = 5'h16, func_set_cmd = 5'h17,
		reset_cmd = 5'h18, op_bad = 5'h19
	} rcd_op_e;

	typedef enum logic [3:0] {
		rk_trig_sig = 4'h1, rk_unst_sig = 4'h2, rk_cur_logic = 4'h3,
		rk_trig_logic = 4'h4, rk_error = 4'h5, rk_pol = 4'h6, rk_id = 4'h7,
		rk_trig_bit = 4'h8
	} rcd_resp_e;
endpackage : rcd_pkg

/* logic/rcd_cmd_decode.sv */
// Classifies a three-character command into an operation
`timescale 1ns/1ps
module rcd_cmd_decode (
	input wire logic [7:0] c0,
	input wire logic [7:0] c1,
	input wire logic [7:0] c2,
	output rcd_pkg::rcd_op_e op,
	output logic [2:0] sel,
	output logic val
);
	logic is12;
	logic is01;
	logic two;
	assign is12 = (c2 == rcd_pkg::CH_1) || (c2 == rcd_pkg::CH_2);
	assign is01 = (c2 == rcd_pkg::CH_0) || (c2 == rcd_pkg::CH_1);
	assign two = (c2 == rcd_pkg::CH_NUL);

	always_comb
	begin
		op = rcd_pkg::op_bad;
		sel = 3'h0;
		val = (c2 == rcd_pkg::CH_1);
		case (c0)
			rcd_pkg::CH_P:
			begin
				case (c1)
					rcd_pkg::CH_T: if (is12) op = val ? rcd_pkg::start_rise_cmd : rcd_pkg::start_fall_cmd;
					rcd_pkg::CH_P: if (is12) op = val ? rcd_pkg::stop_rise_cmd : rcd_pkg::stop_fall_cmd;
					rcd_pkg::CH_Q: if (is12) op = val ? rcd_pkg::qualifier_high_cmd : rcd_pkg::qualifier_low_cmd;
					rcd_pkg::CH_C: if (is12) op = val ? rcd_pkg::clk_rise_cmd : rcd_pkg::clk_fall_cmd;
					rcd_pkg::CH_S:
						if (is01)
							op = val ? rcd_pkg::probe_switch_on_cmd : rcd_pkg::probe_switch_off_cmd;
					default: op = rcd_pkg::op_bad;
				endcase
			end
			rcd_pkg::CH_S:
			begin
				case (c1)
					rcd_pkg::CH_S:
						if (is12)
							op = val ? rcd_pkg::send_triggered_signature_cmd
								: rcd_pkg::send_unstable_signature_cmd;
					rcd_pkg::CH_L:
						if (is12)
							op = val ? rcd_pkg::send_current_logic_cmd : rcd_pkg::send_triggered_logic_cmd;
					rcd_pkg::CH_E: if (two) op = rcd_pkg::send_error_cmd;
					rcd_pkg::CH_P: if (two) op = rcd_pkg::send_pol_cmd;
					rcd_pkg::CH_I: if (two) op = rcd_pkg::send_id_cmd;
					rcd_pkg::CH_T: if (two) op = rcd_pkg::send_trig_bit_cmd;
					default: op = rcd_pkg::op_bad;
				endcase
			end
			rcd_pkg::CH_I: if (c1 == rcd_pkg::CH_D && two) op = rcd_pkg::send_id_cmd;
			rcd_pkg::CH_R:
			begin
				if (two && c1 >= rcd_pkg::CH_A && c1 <= rcd_pkg::CH_D)
				begin
					op = rcd_pkg::load_digit_cmd;
					sel = 3'(c1 - rcd_pkg::CH_A);
				end
				else if (two && c1 == rcd_pkg::CH_P)
					op = rcd_pkg::load_pol_cmd;
				else if (two && c1 == rcd_pkg::CH_S)
					op = rcd_pkg::reset_cmd;
			end
			rcd_pkg::CH_F:
			begin
				val = (c2 == rcd_pkg::CH_1);
				case (c1)
					rcd_pkg::CH_0: if (two) op = rcd_pkg::preset_norm_cmd;
					rcd_pkg::CH_1: if (two) op = rcd_pkg::preset_qualifier_input_cmd;
					rcd_pkg::CH_R, rcd_pkg::CH_E, rcd_pkg::CH_S, rcd_pkg::CH_U, rcd_pkg::CH_Q:
						if (is01) op = rcd_pkg::func_set_cmd;
					default: op = rcd_pkg::op_bad;
				endcase
				case (c1)
					rcd_pkg::CH_E: sel = 3'h1;
					rcd_pkg::CH_S: sel = 3'h2;
					rcd_pkg::CH_U: sel = 3'h3;
					rcd_pkg::CH_Q: sel = 3'h4;
					default: sel = 3'h0;
				endcase
			end
			default: op = rcd_pkg::op_bad;
		endcase
	end
endmodule : rcd_cmd_decode

/* logic/rcd_top.sv */
// Remote command decoder: register port, polarity, window and response logic
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rcd_top #(
	parameter int SIG_W = 16,
	parameter int DIGIT_W = 8,
	parameter logic [15:0] ID_CODE = 16'h5a3c // Arbitrary identity value
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_q,
	input wire logic start_in,
	input wire logic stop_in,
	input wire logic qualifier_input,
	input wire logic probe_clk_in,
	input wire logic probe_switch_in,
	input wire logic [rcd_pkg::TIP_W-1:0] probe_tip_in,
	input wire logic sig_valid_in,
	input wire logic sig_unstable_in,
	input wire logic [SIG_W-1:0] signature_in,
	output logic window_open_q,
	output logic sig_accept_q,
	output logic clk_fall_q,
	output logic start_fall_q,
	output logic stop_fall_q,
	output logic qualifier_input_low_q,
	output logic [rcd_pkg::FN_W-1:0] func_q,
	output logic probe_en_q,
	output logic [rcd_pkg::NUM_DIGITS*DIGIT_W-1:0] digits_q,
	output logic [31:0] resp_q,
	output logic resp_ready_q,
	output logic irq_q
);
	generate
		if (SIG_W < 1 || SIG_W > rcd_pkg::RESP_KIND_LSB || DIGIT_W < 1 || DIGIT_W > 8)
		begin : g_bad_param
			$error("rcd_top: unsupported SIG_W or DIGIT_W");
		end
	endgenerate

	//--------------------------------------------------------------------
	// Command decode
	//--------------------------------------------------------------------
	rcd_pkg::rcd_op_e dec_op;
	rcd_pkg::rcd_op_e op_g;
	logic [2:0] dec_sel;
	logic dec_val;
	logic [7:0] arg;
	logic cmd_wr;

	rcd_cmd_decode u_dec (
		.c0(wdata[rcd_pkg::CMD_C0_LSB +: 8]),
		.c1(wdata[rcd_pkg::CMD_C1_LSB +: 8]),
		.c2(wdata[rcd_pkg::CMD_C2_LSB +: 8]),
		.op(dec_op),
		.sel(dec_sel),
		.val(dec_val)
	);

	assign cmd_wr = wr && (addr == rcd_pkg::OFF_CMD);
	assign op_g = cmd_wr ? dec_op : rcd_pkg::op_none;
	assign arg = wdata[rcd_pkg::CMD_ARG_LSB +: 8];

	//--------------------------------------------------------------------
	// Settings
	//--------------------------------------------------------------------
	// An unknown code falls to the default branch, so nothing changes
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			clk_fall_q <= 1'b0;
			start_fall_q <= 1'b0;
			stop_fall_q <= 1'b0;
			qualifier_input_low_q <= 1'b0;
			func_q <= rcd_pkg::FN_RST;
			probe_en_q <= rcd_pkg::PROBE_EN_RST;
		end
		else
		begin
			case (op_g)
				rcd_pkg::start_rise_cmd: start_fall_q <= 1'b0;
				rcd_pkg::start_fall_cmd: start_fall_q <= 1'b1;
				rcd_pkg::stop_rise_cmd: stop_fall_q <= 1'b0;
				rcd_pkg::stop_fall_cmd: stop_fall_q <= 1'b1;
				rcd_pkg::qualifier_high_cmd: qualifier_input_low_q <= 1'b0;
				rcd_pkg::qualifier_low_cmd: qualifier_input_low_q <= 1'b1;
				rcd_pkg::clk_rise_cmd: clk_fall_q <= 1'b0;
				rcd_pkg::clk_fall_cmd: clk_fall_q <= 1'b1;
				rcd_pkg::probe_switch_off_cmd:
				begin
					probe_en_q <= 1'b0;
					func_q <= func_q & ~rcd_pkg::FN_PROBE_CLR;
				end
				rcd_pkg::probe_switch_on_cmd:
				begin
					probe_en_q <= 1'b1;
					func_q <= func_q & ~rcd_pkg::FN_PROBE_CLR;
				end
				rcd_pkg::preset_norm_cmd: func_q <= rcd_pkg::FN_RST;
				rcd_pkg::preset_qualifier_input_cmd: func_q <= rcd_pkg::FN_PRESET_QUALIFIER_INPUT;
				rcd_pkg::func_set_cmd: func_q[dec_sel] <= dec_val;
				rcd_pkg::load_pol_cmd:
				begin
					clk_fall_q <= ~arg[rcd_pkg::RP_CLK_BIT];
					start_fall_q <= ~arg[rcd_pkg::RP_START_BIT];
					stop_fall_q <= ~arg[rcd_pkg::RP_STOP_BIT];
				end
				rcd_pkg::reset_cmd:
				begin
					clk_fall_q <= 1'b0;
					start_fall_q <= 1'b0;
					stop_fall_q <= 1'b0;
					qualifier_input_low_q <= 1'b0;
					func_q <= rcd_pkg::FN_RST;
					probe_en_q <= rcd_pkg::PROBE_EN_RST;
				end
				default: ;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// Edge detection, window and clock qualification
	//--------------------------------------------------------------------
	logic start_prev_q;
	logic stop_prev_q;
	logic pclk_prev_q;
	logic sw_prev_q;
	logic start_ev;
	logic stop_ev;
	logic clk_ev;
	logic qualifier_input_ok;
	logic press;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			start_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
			pclk_prev_q <= 1'b0;
			sw_prev_q <= 1'b0;
		end
		else
		begin
			start_prev_q <= start_in;
			stop_prev_q <= stop_in;
			pclk_prev_q <= probe_clk_in;
			sw_prev_q <= probe_switch_in;
		end
	end

	assign start_ev = start_fall_q ? (start_prev_q && !start_in)
		: (!start_prev_q && start_in);
	assign stop_ev = stop_fall_q ? (stop_prev_q && !stop_in) : (!stop_prev_q && stop_in);
	assign clk_ev = clk_fall_q ? (pclk_prev_q && !probe_clk_in) : (!pclk_prev_q && probe_clk_in);
	assign qualifier_input_ok = !func_q[rcd_pkg::FN_QUALIFIER_INPUT] || (qualifier_input == !qualifier_input_low_q);
	// A disabled switch is ignored entirely
	assign press = probe_en_q && !sw_prev_q && probe_switch_in;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			window_open_q <= 1'b0;
		else if (window_open_q && stop_ev)
			window_open_q <= 1'b0;
		else if (start_ev)
			window_open_q <= 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			sig_accept_q <= 1'b0;
		else
			sig_accept_q <= window_open_q && clk_ev && qualifier_input_ok;
	end

	//--------------------------------------------------------------------
	// Pending sends and response word
	//--------------------------------------------------------------------
	logic trig_arm_q;
	logic trig_seen_q;
	logic unst_arm_q;
	logic trig_bit_q;
	logic error_q;
	logic [rcd_pkg::TIP_W-1:0] trig_logic_q;
	logic resp_set;
	logic sig_done;
	logic [31:0] resp_d;

	assign sig_done = trig_seen_q && sig_valid_in;

	// One response slot: a later send overwrites an uncollected one
	always_comb
	begin
		resp_set = 1'b0;
		resp_d = 32'h0;
		if (sig_done)
		begin
			resp_set = 1'b1;
			resp_d[rcd_pkg::RESP_KIND_LSB +: 4] = rcd_pkg::rk_trig_sig;
			resp_d[SIG_W-1:0] = signature_in;
		end
		else if (unst_arm_q && sig_valid_in && sig_unstable_in)
		begin
			resp_set = 1'b1;
			resp_d[rcd_pkg::RESP_KIND_LSB +: 4] = rcd_pkg::rk_unst_sig;
			resp_d[SIG_W-1:0] = signature_in;
		end
		case (op_g)
			rcd_pkg::send_current_logic_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_cur_logic, 28'h0};
				resp_d[rcd_pkg::TIP_W-1:0] = probe_tip_in;
			end
			rcd_pkg::send_triggered_logic_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_trig_logic, 28'h0};
				resp_d[rcd_pkg::TIP_W-1:0] = trig_logic_q;
			end
			rcd_pkg::send_error_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_error, 27'h0, error_q};
			end
			rcd_pkg::send_pol_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_pol, 24'h0, qualifier_input_low_q, stop_fall_q, start_fall_q, clk_fall_q};
			end
			rcd_pkg::send_id_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_id, 12'h0, ID_CODE};
			end
			rcd_pkg::send_trig_bit_cmd:
			begin
				resp_set = 1'b1;
				resp_d = {rcd_pkg::rk_trig_bit, 27'h0, trig_bit_q};
			end
			default: ;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			trig_arm_q <= 1'b0;
			trig_seen_q <= 1'b0;
			unst_arm_q <= 1'b0;
		end
		else
		begin
			if (op_g == rcd_pkg::send_triggered_signature_cmd || op_g == rcd_pkg::probe_switch_on_cmd)
			begin
				trig_arm_q <= 1'b1;
				trig_seen_q <= 1'b0;
			end
			else if (sig_done)
			begin
				trig_arm_q <= 1'b0;
				trig_seen_q <= 1'b0;
			end
			else if (trig_arm_q && press)
				trig_seen_q <= 1'b1;
			if (op_g == rcd_pkg::send_unstable_signature_cmd)
				unst_arm_q <= 1'b1;
			else if (!sig_done && sig_valid_in && sig_unstable_in)
				unst_arm_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			trig_bit_q <= 1'b0;
			trig_logic_q <= '0;
			error_q <= 1'b0;
		end
		else
		begin
			if (press)
			begin
				trig_bit_q <= 1'b1;
				trig_logic_q <= probe_tip_in;
			end
			else if (op_g == rcd_pkg::send_trig_bit_cmd)
				trig_bit_q <= 1'b0;
			if (op_g == rcd_pkg::op_bad)
				error_q <= 1'b1;
			else if (op_g == rcd_pkg::send_error_cmd)
				error_q <= 1'b0;
		end
	end

	// Set wins over the clear that a read of the response gives
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			resp_ready_q <= 1'b0;
			resp_q <= 32'h0;
		end
		else if (resp_set)
		begin
			resp_ready_q <= 1'b1;
			resp_q <= resp_d;
		end
		else if (rd && addr == rcd_pkg::OFF_RESP)
			resp_ready_q <= 1'b0;
	end

	//--------------------------------------------------------------------
	// Display digits
	//--------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < rcd_pkg::NUM_DIGITS; gi++)
		begin : g_digit
			always_ff @(posedge mclk or posedge rst)
			begin
				if (rst)
					digits_q[gi*DIGIT_W +: DIGIT_W] <= '0;
				else if (op_g == rcd_pkg::load_digit_cmd && dec_sel == 3'(gi))
					digits_q[gi*DIGIT_W +: DIGIT_W] <= arg[DIGIT_W-1:0];
			end
		end
	endgenerate

	//--------------------------------------------------------------------
	// Interrupts and register reads
	//--------------------------------------------------------------------
	logic [rcd_pkg::INT_W-1:0] int_status_q;
	logic [rcd_pkg::INT_W-1:0] int_status_d;
	logic [rcd_pkg::INT_W-1:0] int_mask_q;
	logic [rcd_pkg::INT_W-1:0] int_ev;
	logic [rcd_pkg::INT_W-1:0] int_clr;

	always_comb
	begin
		int_ev = '0;
		int_ev[rcd_pkg::INT_RESP] = resp_set;
		int_ev[rcd_pkg::INT_ERR] = (op_g == rcd_pkg::op_bad);
		int_ev[rcd_pkg::INT_TRIG] = press;
		int_clr = (wr && addr == rcd_pkg::OFF_INT_STATUS) ? wdata[rcd_pkg::INT_W-1:0] : '0;
		int_status_d = (int_status_q & ~int_clr) | int_ev;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			int_status_q <= '0;
			int_mask_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			int_status_q <= int_status_d;
			if (wr && addr == rcd_pkg::OFF_INT_MASK)
				int_mask_q <= wdata[rcd_pkg::INT_W-1:0];
			irq_q <= |(int_status_d & int_mask_q);
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			rdata_q <= 32'h0;
		else if (!rd)
			rdata_q <= 32'h0;
		else
		begin
			rdata_q <= 32'h0;
			case (addr)
				rcd_pkg::OFF_SETTINGS: rdata_q <= {21'h0, error_q, probe_en_q, qualifier_input_low_q,
					stop_fall_q, start_fall_q, clk_fall_q, func_q};
				rcd_pkg::OFF_RESP: rdata_q <= resp_q;
				rcd_pkg::OFF_DIGITS: rdata_q <= 32'(digits_q);
				rcd_pkg::OFF_INT_STATUS: rdata_q <= 32'(int_status_q);
				rcd_pkg::OFF_INT_MASK: rdata_q <= 32'(int_mask_q);
				default: rdata_q <= 32'h0;
			endcase
		end
	end

	//--------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_start_fall;
		(start_fall_q && !window_open_q && start_prev_q && !start_in) |=> window_open_q;
	endproperty
	a_start_fall: assert property (p_start_fall) else $error("falling start missed");
	property p_start_rise;
		(op_g == rcd_pkg::start_rise_cmd) |=> !start_fall_q;
	endproperty
	a_start_rise: assert property (p_start_rise) else $error("start not rising");
	property p_stop_fall_only;
		(window_open_q && stop_fall_q && !stop_prev_q && stop_in) |=> window_open_q;
	endproperty
	a_stop_fall_only: assert property (p_stop_fall_only) else $error("rising stop closed");
	property p_stop_close;
		(window_open_q && !stop_fall_q && !stop_prev_q && stop_in) |=> !window_open_q;
	endproperty
	a_stop_close: assert property (p_stop_close) else $error("rising stop kept open");
	property p_qualifier_input;
		(func_q[rcd_pkg::FN_QUALIFIER_INPUT] && (qualifier_input == qualifier_input_low_q)) |=> !sig_accept_q;
	endproperty
	a_qualifier_input: assert property (p_qualifier_input) else $error("clock taken at wrong qualifier");
	property p_probe_off;
		(op_g == rcd_pkg::probe_switch_off_cmd) |=> !probe_en_q && !func_q[rcd_pkg::FN_RECALL]
			##1 !int_ev[rcd_pkg::INT_TRIG];
	endproperty
	a_probe_off: assert property (p_probe_off) else $error("probe off incomplete");
	property p_probe_on;
		(op_g == rcd_pkg::probe_switch_on_cmd) |=> probe_en_q && trig_arm_q
			&& ((func_q & rcd_pkg::FN_PROBE_CLR) == '0);
	endproperty
	a_probe_on: assert property (p_probe_on) else $error("probe on incomplete");
	property p_trig_sig;
		(sig_done && op_g == rcd_pkg::op_none) |=> resp_ready_q
			&& resp_q[SIG_W-1:0] == $past(signature_in);
	endproperty
	a_trig_sig: assert property (p_trig_sig) else $error("triggered signature lost");
	property p_unst_sig;
		(unst_arm_q && !sig_done && sig_valid_in && sig_unstable_in && op_g == rcd_pkg::op_none)
			|=> resp_q[rcd_pkg::RESP_KIND_LSB +: 4] == rcd_pkg::rk_unst_sig;
	endproperty
	a_unst_sig: assert property (p_unst_sig) else $error("unstable signature lost");
	property p_cur_logic;
		(op_g == rcd_pkg::send_current_logic_cmd) |=> resp_q[rcd_pkg::TIP_W-1:0] == $past(probe_tip_in);
	endproperty
	a_cur_logic: assert property (p_cur_logic) else $error("current logic wrong");
	property p_bad;
		(op_g == rcd_pkg::op_bad) |=> error_q && $stable(func_q)
			&& $stable(start_fall_q) && $stable(probe_en_q);
	endproperty
	a_bad: assert property (p_bad) else $error("bad command altered state");
endmodule : rcd_top

/* sim/rcd_ctrl_model.sv */
// Bus controller model driving the register port
`timescale 1ns/1ps
module rcd_ctrl_model (
	input wire logic mclk,
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata_q
);
	// ----
	// Bus cycles
	// ----
	initial
	begin
		{addr, wdata, wr, rd} = 42'h0;
	end
	// Idle address and data flip so stale values never look valid
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : put
	// Caller collects each response before the next send
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		addr <= ~a;
		#1;
		d = rdata_q;
	endtask : get
endmodule : rcd_ctrl_model

/* sim/tb.sv */
// Self-checking bench for the remote command decoder
`timescale 1ns/1ps
module tb;
	logic mclk, rst, wr, rd, start_in, stop_in, qualifier_input, probe_clk_in;
	logic probe_switch_in, sig_valid_in, sig_unstable_in, window_open_q, sig_accept_q;
	logic clk_fall_q, start_fall_q, stop_fall_q, qualifier_input_low_q, probe_en_q, resp_ready_q, irq_q;
	logic [7:0] addr;
	logic [31:0] wdata, rdata_q, digits_q, resp_q, v, es;
	logic [1:0] probe_tip_in;
	logic [15:0] signature_in;
	logic [4:0] func_q;
	integer err_count = 0, samples_checked = 0, seed = 49102, n;
	string fl = "RESU";
	rcd_top DUT (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rdata_q), .start_in(start_in), .stop_in(stop_in),
		.qualifier_input(qualifier_input), .probe_clk_in(probe_clk_in),
		.probe_switch_in(probe_switch_in), .probe_tip_in(probe_tip_in),
		.sig_valid_in(sig_valid_in), .sig_unstable_in(sig_unstable_in),
		.signature_in(signature_in), .window_open_q(window_open_q), .sig_accept_q(sig_accept_q),
		.clk_fall_q(clk_fall_q), .start_fall_q(start_fall_q), .stop_fall_q(stop_fall_q),
		.qualifier_input_low_q(qualifier_input_low_q), .func_q(func_q), .probe_en_q(probe_en_q), .digits_q(digits_q),
		.resp_q(resp_q), .resp_ready_q(resp_ready_q), .irq_q(irq_q)
	);
	rcd_ctrl_model ctl (
		.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q)
	);
	// ----
	// Helpers
	// ----
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic cmd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
		input logic [7:0] g);
		ctl.put(rcd_pkg::OFF_CMD, {g, a, b, c});
		#1;
	endtask : cmd
	task automatic setchk(input logic [31:0] e);
		ctl.get(rcd_pkg::OFF_SETTINGS, v);
		chk("settings", e, v);
		chk("pol", 32'(e[8:6]), 32'({qualifier_input_low_q, stop_fall_q, start_fall_q}));
	endtask : setchk
	// Response word is collected and the pending flag must drop
	task automatic rsp(input logic [3:0] k, input logic [15:0] p);
		chk("ready", 32'h1, 32'(resp_ready_q));
		chk("resp", {k, 12'h0, p}, resp_q);
		ctl.get(rcd_pkg::OFF_RESP, v);
		chk("rdata", {k, 12'h0, p}, v);
		chk("ready", 32'h0, 32'(resp_ready_q));
	endtask : rsp
	task automatic sig(input logic u);
		signature_in <= 16'($random(seed));
		sig_unstable_in <= u;
		sig_valid_in <= 1'b1;
		cyc(1);
		sig_valid_in <= 1'b0;
		cyc(2);
	endtask : sig
	task automatic press(input logic [1:0] t);
		probe_tip_in <= t;
		probe_switch_in <= 1'b1;
		cyc(3);
		probe_switch_in <= 1'b0;
		cyc(2);
	endtask : press
	task automatic pin(input logic [1:0] ss, input logic e);
		{start_in, stop_in} <= ss;
		cyc(4);
		chk("window", 32'(e), 32'(window_open_q));
	endtask : pin
	// One rising probe clock; accepts counted over the five cycles after the rise only
	task automatic clk_edge(input logic q, input int e);
		qualifier_input <= q;
		cyc(2);
		probe_clk_in <= 1'b1;
		n = 0;
		repeat (5)
		begin
			cyc(1);
			n += sig_accept_q;
		end
		probe_clk_in <= 1'b0;
		cyc(3);
		chk("accepts", e, n);
	endtask : clk_edge
	// ----
	// Scenarios
	// ----
	initial
	begin
		{rst, start_in, stop_in, qualifier_input, probe_clk_in, probe_switch_in} = 6'h20;
		{sig_valid_in, sig_unstable_in, probe_tip_in, signature_in} = 20'h0;
		cyc(6);
		rst <= 1'b0;
		cyc(1);
		setchk(32'h200);
		es = 32'h200;
		for (int i = 0; i < 12; i++)
		begin
			n = (i < 6) ? i : {$random(seed)} % 6;
			cmd("P", (n < 2) ? "T" : (n < 4) ? "P" : "Q", rcd_pkg::CH_1 + 8'(n % 2), 8'h0);
			es[rcd_pkg::SET_START_FALL + n / 2] = n % 2;
			setchk(es);
		end
		cmd("P", "T", "2", 8'h0);
		cmd("P", "P", "2", 8'h0);
		pin(2'b10, 1'b0);
		pin(2'b00, 1'b1);
		pin(2'b01, 1'b1);
		pin(2'b00, 1'b0);
		pin(2'b10, 1'b0);
		pin(2'b00, 1'b1);
		cmd("F", "1", 8'h0, 8'h0);
		chk("func", 32'h10, 32'(func_q));
		cmd("P", "Q", "1", 8'h0);
		clk_edge(1'b1, 1);
		clk_edge(1'b0, 0);
		cmd("P", "Q", "2", 8'h0);
		clk_edge(1'b0, 1);
		clk_edge(1'b1, 0);
		cmd("P", "P", "1", 8'h0);
		pin(2'b01, 1'b0);
		cmd("P", "P", "2", 8'h0);
		for (int p = 0; p < 2; p++)
		begin
			for (int j = 0; j < 4; j++)
				cmd("F", fl[j], "1", 8'h0);
			chk("func", 32'h1f, 32'(func_q));
			cmd("P", "S", rcd_pkg::CH_0 + 8'(p), 8'h0);
			chk("func", 32'h10, 32'(func_q));
			chk("probe_en", 32'(p), 32'(probe_en_q));
			sig(1'b0);
			chk("ready", 32'h0, 32'(resp_ready_q));
			press(2'(p + 1));
			ctl.get(rcd_pkg::OFF_INT_STATUS, v);
			chk("press", 32'(p), 32'(v[2]));
		end
		chk("irq", 32'h0, 32'(irq_q));
		sig(1'b0);
		rsp(4'h1, signature_in);
		cmd("S", "S", "2", 8'h0);
		sig(1'b0);
		chk("ready", 32'h0, 32'(resp_ready_q));
		sig(1'b1);
		rsp(4'h2, signature_in);
		probe_tip_in <= 2'b01;
		cmd("S", "L", "2", 8'h0);
		rsp(4'h4, 16'h2);
		cmd("S", "L", "1", 8'h0);
		rsp(4'h3, 16'h1);
		es = 32'h0;
		for (int j = 0; j < 4; j++)
		begin
			v = $random(seed);
			cmd("R", rcd_pkg::CH_A + 8'(j), 8'h0, v[7:0]);
			es[8 * j +: 8] = v[7:0];
			chk("digits", es, digits_q);
		end
		ctl.put(rcd_pkg::OFF_INT_MASK, 32'h2);
		cmd("Z", "Q", "9", 8'h0);
		setchk(32'h7d0);
		chk("irq", 32'h1, 32'(irq_q));
		ctl.put(rcd_pkg::OFF_INT_STATUS, 32'h2);
		cyc(1);
		chk("irq", 32'h0, 32'(irq_q));
		cmd("S", "E", 8'h0, 8'h0);
		rsp(4'h5, 16'h1);
		cmd("I", "D", 8'h0, 8'h0);
		rsp(4'h7, 16'h5a3c);
		cmd("S", "I", 8'h0, 8'h0);
		rsp(4'h7, 16'h5a3c);
		cmd("P", "C", "2", 8'h0);
		chk("clk_fall", 32'h1, 32'(clk_fall_q));
		cmd("R", "P", 8'h0, 8'h1);
		chk("pol", 32'h6, 32'({stop_fall_q, start_fall_q, clk_fall_q}));
		cmd("S", "P", 8'h0, 8'h0);
		rsp(4'h6, 16'he);
		cmd("S", "T", 8'h0, 8'h0);
		rsp(4'h8, 16'h1);
		cmd("S", "T", 8'h0, 8'h0);
		rsp(4'h8, 16'h0);
		cmd("F", "0", 8'h0, 8'h0);
		chk("func", 32'h0, 32'(func_q));
		cmd("F", "Q", "1", 8'h0);
		chk("func", 32'h10, 32'(func_q));
		cmd("R", "S", 8'h0, 8'h0);
		setchk(32'h200);
		results();
	end
	// Run needs well under a thousand cycles; this allows ample slack
	initial
	begin
		#2000000;
		err_count++;
		results();
	end
endmodule : tb
